// ### bench/lamp_checker_sva.sv
`timescale 1ns/1ps
module lamp_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic awake_i,
   input wire logic tracking_mode_i,
   input wire logic emergency_i,
   input wire logic [2:0] signal_bars_i,
   input wire logic [1:0] fix_quality_i,
   input wire logic [6:0] charge_pct_i,
   input wire logic charging_i,
   input wire logic tx_success_i,
   input wire logic [1:0] wireless_state_i,
   input wire logic usb_power_i,
   input wire logic power_lamp_o,
   input wire logic satellite_link_lamp_o,
   input wire logic position_lamp_o,
   input wire logic battery_charge_lamp_o,
   input wire logic status_lamp_o,
   input wire logic wireless_pairing_lamp_o
);
   logic [9:0] en;
   logic usb_seen;
   // no override sequence can be running
   wire q = !usb_seen && !emergency_i;
   wire wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
      wb_adr_i == lamp_pkg::ADDR_ENABLE;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en <= lamp_pkg::EN_RESET;
         usb_seen <= 1'b0;
      end else begin
         usb_seen <= usb_seen | usb_power_i;
         if (wr && wb_sel_i[0]) en[7:0] <= wb_dat_i[7:0];
         if (wr && wb_sel_i[1]) en[9:8] <= wb_dat_i[9:8];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
      |=> wb_ack_o) else $error("request not acknowledged");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_link_dark: assert property (
      (q && signal_bars_i == 3'h0)[*5] |=> !satellite_link_lamp_o)
      else $error("link lamp lit at zero bars");
   chk_link_solid: assert property (
      (q && en[4] && signal_bars_i >= 3'h3 && signal_bars_i <= 3'h5)[*5]
      |=> satellite_link_lamp_o) else $error("link lamp not solid");
   chk_pos_dark: assert property (
      (q && fix_quality_i == lamp_pkg::FIX_NONE)[*5] |=> !position_lamp_o)
      else $error("position lamp lit without fix");
   chk_pos_solid: assert property (
      (q && en[5] && fix_quality_i == lamp_pkg::FIX_VALID)[*5]
      |=> position_lamp_o) else $error("position lamp not solid");
   chk_wl_solid: assert property (
      (q && en[8] && wireless_state_i == lamp_pkg::WL_PAIRED)[*5]
      |=> wireless_pairing_lamp_o) else $error("wireless lamp not solid");
   chk_battery_charge_lamp_solid: assert property (
      (q && en[6] && !charging_i && charge_pct_i > 7'h50)[*5]
      |=> battery_charge_lamp_o) else $error("battery lamp not solid");
   chk_power_awake: assert property (
      (q && awake_i && en[2])[*5] |=> power_lamp_o)
      else $error("power lamp not solid while awake");
   chk_status_clear: assert property (
      (q && tracking_mode_i != $past(tracking_mode_i)) ##1
      (q && !tx_success_i)[*4] |=> !status_lamp_o)
      else $error("status lamp kept after mode switch");
endmodule

// ### bench/lamp_panel.sv
`timescale 1ns/1ps
module lamp_panel (
   input wire logic power_lamp_o,
   input wire logic satellite_link_lamp_o,
   input wire logic position_lamp_o,
   input wire logic battery_charge_lamp_o,
   input wire logic status_lamp_o,
   input wire logic wireless_pairing_lamp_o,
   output logic [5:0] lit_o
);
   // which lamps are lit, power lamp in bit 0
   assign lit_o = {wireless_pairing_lamp_o, status_lamp_o,
      battery_charge_lamp_o, position_lamp_o, satellite_link_lamp_o,
      power_lamp_o};
endmodule

// ### bench/status_led_indicator_controller_test.sv
`timescale 1ns/1ps
module status_led_indicator_controller_test;
   logic clk_i = 1'b0, rst_i = 1'b1;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, d;
   logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
   logic awake_i = 1'b0, powered_i = 1'b0, tracking_mode_i = 1'b1;
   logic emergency_i = 1'b0, charging_i = 1'b0, charge_done_i = 1'b0;
   logic tx_success_i = 1'b0, tx_fail_i = 1'b0, usb_power_i = 1'b0;
   logic [2:0] signal_bars_i = 3'h0;
   logic [1:0] fix_quality_i = 2'h0, wireless_state_i = 2'h0;
   logic [6:0] charge_pct_i = 7'h0;
   logic power_lamp_o, satellite_link_lamp_o, position_lamp_o;
   logic battery_charge_lamp_o, status_lamp_o, wireless_pairing_lamp_o;
   logic [5:0] lit_o;
   int fail_count = 0, n_compared = 0;
   always #2.5 clk_i = ~clk_i;
   status_led_indicator_controller i_dut (.*);
   lamp_panel i_panel (.*);
   task end_of_test;
      if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wb(input logic w, input logic [3:0] a, input logic [31:0] v);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= v;
      wb_sel_i <= 4'hF;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         fail_count++;
         $display("Error at %0t: bus timeout", $time);
         end_of_test();
      end
      d = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task settle;
      repeat (8) @(posedge clk_i);
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, lamp_pkg::ADDR_ENABLE, 32'h0);
      check(d, {22'h0, lamp_pkg::EN_RESET});
      awake_i <= 1'b1;
      powered_i <= 1'b1;
      signal_bars_i <= 3'h4;
      fix_quality_i <= lamp_pkg::FIX_VALID;
      charge_pct_i <= 7'h5A;
      wireless_state_i <= lamp_pkg::WL_PAIRED;
      tx_success_i <= 1'b1;
      @(posedge clk_i);
      tx_success_i <= 1'b0;
      settle();
      check({26'h0, lit_o}, 32'h3F);
      wb(1'b0, lamp_pkg::ADDR_LAMPS, 32'h0);
      check(d, 32'h3F);
      tracking_mode_i <= 1'b0;
      settle();
      check({26'h0, lit_o}, 32'h2F);
      signal_bars_i <= 3'h0;
      fix_quality_i <= lamp_pkg::FIX_NONE;
      wireless_state_i <= lamp_pkg::WL_OFF;
      settle();
      check({26'h0, lit_o}, 32'h09);
      emergency_i <= 1'b1;
      settle();
      check({26'h0, lit_o}, 32'h3F);
      wb(1'b0, lamp_pkg::ADDR_STATE, 32'h0);
      check(d, 32'h03);
      emergency_i <= 1'b0;
      settle();
      check({26'h0, lit_o}, 32'h09);
      wb(1'b1, lamp_pkg::ADDR_ENABLE, 32'h3BB);
      settle();
      check({26'h0, lit_o}, 32'h0);
      wb(1'b0, 4'hC, 32'h0);
      check(d, 32'h0);
      wb(1'b0, lamp_pkg::ADDR_ENABLE, 32'h0);
      check(d, 32'h3BB);
      usb_power_i <= 1'b1;
      settle();
      check({26'h0, lit_o}, 32'h08);
      wb(1'b0, lamp_pkg::ADDR_STATE, 32'h0);
      check(d, 32'h11);
      end_of_test();
   end
endmodule
bind status_led_indicator_controller lamp_checker i_chk (.*);

// ### core/lamp_pkg.sv
package lamp_pkg;
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned TICK_HZ = 1000;
   localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;
   // times in milliseconds
   localparam int unsigned SLEEP_EMERG_MS = 2500;
   localparam int unsigned SLEEP_NORM_MS = 5000;
   localparam int unsigned BLINK_ON_MS = 125;
   localparam int unsigned EMERG_HALF_MS = 1000;
   localparam int unsigned MID_ON_MS = 1250;
   localparam int unsigned MID_OFF_MS = 250;
   localparam int unsigned LOW_ON_MS = 125;
   localparam int unsigned LOW_OFF_MS = 1000;
   localparam int unsigned COMMON_HALF_MS = 500;
   localparam int unsigned CONNECT_MS = 3000;
   localparam int unsigned CONNECT_STEP_MS = 250;
   localparam int unsigned CHARGE_HIGH_PCT = 80;
   localparam int unsigned CHARGE_LOW_PCT = 20;
   localparam int unsigned BARS_SOLID = 3;
   // lamp enable bit positions
   localparam int unsigned EN_ASLEEP_NORM = 0;
   localparam int unsigned EN_ASLEEP_EMERG = 1;
   localparam int unsigned EN_AWAKE_NORM = 2;
   localparam int unsigned EN_EMERG_SEQ = 3;
   localparam int unsigned EN_LINK = 4;
   localparam int unsigned EN_POS = 5;
   localparam int unsigned EN_BATTERY_CHARGE_LAMP = 6;
   localparam int unsigned EN_STATUS = 7;
   localparam int unsigned EN_WIRELESS = 8;
   localparam int unsigned EN_CONNECT = 9;
   localparam int unsigned EN_W = 10;
   localparam logic [9:0] EN_RESET = 10'h3FF;
   // lamp output bit positions
   localparam int unsigned L_POWER = 0;
   localparam int unsigned L_LINK = 1;
   localparam int unsigned L_POS = 2;
   localparam int unsigned L_BATTERY_CHARGE_LAMP = 3;
   localparam int unsigned L_STATUS = 4;
   localparam int unsigned L_WIRELESS = 5;
   localparam int unsigned LAMP_W = 6;
   // register map
   localparam logic [3:0] ADDR_ENABLE = 4'h0;
   localparam logic [3:0] ADDR_STATE = 4'h4;
   localparam logic [3:0] ADDR_LAMPS = 4'h8;
   // fix quality codes
   localparam logic [1:0] FIX_NONE = 2'h0;
   localparam logic [1:0] FIX_PARTIAL = 2'h1;
   localparam logic [1:0] FIX_VALID = 2'h2;
   // wireless state codes
   localparam logic [1:0] WL_OFF = 2'h0;
   localparam logic [1:0] WL_PAIRING = 2'h1;
   localparam logic [1:0] WL_PAIRED = 2'h2;
endpackage

// ### core/status_led_indicator_controller.sv
`timescale 1ns/1ps
module status_led_indicator_controller (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   input wire logic awake_i,
   input wire logic powered_i,
   input wire logic tracking_mode_i,
   input wire logic emergency_i,
   input wire logic [2:0] signal_bars_i,
   input wire logic [1:0] fix_quality_i,
   input wire logic [6:0] charge_pct_i,
   input wire logic charging_i,
   input wire logic charge_done_i,
   input wire logic tx_success_i,
   input wire logic tx_fail_i,
   input wire logic [1:0] wireless_state_i,
   input wire logic usb_power_i,
   output logic power_lamp_o,
   output logic satellite_link_lamp_o,
   output logic position_lamp_o,
   output logic battery_charge_lamp_o,
   output logic status_lamp_o,
   output logic wireless_pairing_lamp_o
);
   localparam int unsigned TC = lamp_pkg::TICK_CYCLES;
   localparam logic [15:0] T_SLP_E = 16'(lamp_pkg::SLEEP_EMERG_MS);
   localparam logic [15:0] T_SLP_N = 16'(lamp_pkg::SLEEP_NORM_MS);
   localparam logic [15:0] T_ON = 16'(lamp_pkg::BLINK_ON_MS);
   localparam logic [15:0] T_EMG = 16'(lamp_pkg::EMERG_HALF_MS);
   localparam logic [15:0] T_MID_ON = 16'(lamp_pkg::MID_ON_MS);
   localparam logic [15:0] T_MID_OFF = 16'(lamp_pkg::MID_OFF_MS);
   localparam logic [15:0] T_LOW_ON = 16'(lamp_pkg::LOW_ON_MS);
   localparam logic [15:0] T_LOW_OFF = 16'(lamp_pkg::LOW_OFF_MS);
   localparam logic [15:0] T_COM = 16'(lamp_pkg::COMMON_HALF_MS);
   localparam logic [15:0] T_CONN = 16'(lamp_pkg::CONNECT_MS);
   localparam logic [15:0] T_STEP = 16'(lamp_pkg::CONNECT_STEP_MS);
   localparam logic [6:0] P_HI = 7'(lamp_pkg::CHARGE_HIGH_PCT);
   localparam logic [6:0] P_LO = 7'(lamp_pkg::CHARGE_LOW_PCT);
   localparam logic [2:0] B_SOLID = 3'(lamp_pkg::BARS_SOLID);

   typedef enum logic [1:0] {TX_NONE, TX_FAILED, TX_OK} tx_hist_t;

   // synchronised copies of the state inputs (from other logic/pins)
   logic [17:0] meta, sync;
   wire [17:0] raw = {usb_power_i, awake_i, powered_i, tracking_mode_i,
      emergency_i, charging_i, charge_done_i, tx_success_i, tx_fail_i,
      wireless_state_i, fix_quality_i, signal_bars_i, 2'h0};
   wire s_usb = sync[17];
   wire s_awake = sync[16];
   wire s_pwr = sync[15];
   wire s_track = sync[14];
   wire s_emerg = sync[13];
   wire s_chg = sync[12];
   wire s_done = sync[11];
   wire s_ok = sync[10];
   wire s_fail = sync[9];
   wire [1:0] s_wl = sync[8:7];
   wire [1:0] s_fix = sync[6:5];
   wire [2:0] s_bars = sync[4:2];
   logic [6:0] pct_meta, s_pct;

   logic [lamp_pkg::EN_W-1:0] enable;
   logic [$clog2(TC)-1:0] pre;
   wire tick = (pre == ($clog2(TC))'(TC - 1));

   // millisecond phase counters, free running except c_conn, which counts only during the connect sequence
   logic [15:0] c_sleep, c_emg, c_com, c_battery_charge_lamp, c_conn;
   logic track_q, usb_q, conn_act, battery_charge_lamp_ph;
   tx_hist_t tx_hist;
   logic [lamp_pkg::LAMP_W-1:0] lamps;

   // two flops per state bit; only the second stage is read downstream
   for (genvar b = 0; b < 18; b++) begin : g_sync
      always_ff @(posedge clk_i) begin
         meta[b] <= raw[b];
         sync[b] <= meta[b];
      end
   end

   // charge level is a slowly moving value from the gauge logic
   for (genvar b = 0; b < 7; b++) begin : g_sync_pct
      always_ff @(posedge clk_i) begin
         pct_meta[b] <= charge_pct_i[b];
         s_pct[b] <= pct_meta[b];
      end
   end

   // millisecond prescaler; every blink counter steps on its pulse
   always_ff @(posedge clk_i) begin
      if (rst_i || tick) begin
         pre <= '0;
      end else begin
         pre <= pre + 1'b1;
      end
   end

   // wishbone slave, one wait state: ack the cycle after stb
   wire wb_go = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wr_en = wb_go && wb_we_i && (wb_adr_i == lamp_pkg::ADDR_ENABLE);
   wire rd_enable = wb_adr_i == lamp_pkg::ADDR_ENABLE;
   wire rd_state = wb_adr_i == lamp_pkg::ADDR_STATE;
   wire rd_lamps = wb_adr_i == lamp_pkg::ADDR_LAMPS;
   wire [31:0] state_word = {27'h0, conn_act, tx_hist, s_emerg, s_awake};
   // unmapped addresses read as zero
   wire [31:0] rd_data = rd_enable ? {22'h0, enable}
      : rd_state ? state_word
      : rd_lamps ? {26'h0, lamps}
      : 32'h0;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         enable <= lamp_pkg::EN_RESET;
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wb_go;
         if (wr_en && wb_sel_i[0]) enable[7:0] <= wb_dat_i[7:0];
         if (wr_en && wb_sel_i[1]) enable[9:8] <= wb_dat_i[9:8];
         if (wb_go && !wb_we_i) begin
            wb_dat_o <= rd_data;
         end
      end
   end

   // blink counters wrap at their full period, the battery one at each on or off length
   wire sleep_emerg = s_emerg && s_track
      && enable[lamp_pkg::EN_ASLEEP_EMERG];
   wire [15:0] slp_per = sleep_emerg ? T_SLP_E : T_SLP_N;
   wire battery_charge_lamp_mid = (s_pct >= P_LO) || s_chg;
   wire [15:0] b_on = battery_charge_lamp_mid ? T_MID_ON : T_LOW_ON;
   wire [15:0] b_off = battery_charge_lamp_mid ? T_MID_OFF : T_LOW_OFF;
   wire [15:0] b_lim = battery_charge_lamp_ph ? b_on : b_off;

   // wrap one tick before the full count so each period is exact
   wire sleep_wrap = c_sleep >= slp_per - 16'h0001;
   wire emg_wrap = c_emg >= T_EMG + T_EMG - 16'h0001;
   wire com_wrap = c_com >= T_COM + T_COM - 16'h0001;
   wire battery_charge_lamp_wrap = c_battery_charge_lamp >= b_lim - 16'h0001;
   wire conn_end = c_conn >= T_CONN - 16'h0001;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         c_sleep <= '0;
      end else if (tick) begin
         if (sleep_wrap) begin
            c_sleep <= '0;
         end else begin
            c_sleep <= c_sleep + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         c_emg <= '0;
      end else if (tick) begin
         if (emg_wrap) begin
            c_emg <= '0;
         end else begin
            c_emg <= c_emg + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         c_com <= '0;
      end else if (tick) begin
         if (com_wrap) begin
            c_com <= '0;
         end else begin
            c_com <= c_com + 16'h0001;
         end
      end
   end

   // battery pattern alternates between its on and off lengths
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         c_battery_charge_lamp <= '0;
         battery_charge_lamp_ph <= 1'b1;
      end else if (tick) begin
         if (battery_charge_lamp_wrap) begin
            c_battery_charge_lamp <= '0;
            battery_charge_lamp_ph <= !battery_charge_lamp_ph;
         end else begin
            c_battery_charge_lamp <= c_battery_charge_lamp + 16'h0001;
         end
      end
   end

   // transmit history; mode switch clears it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_hist <= TX_NONE;
         track_q <= 1'b0;
      end else begin
         track_q <= s_track;
         if (track_q != s_track) tx_hist <= TX_NONE;
         else if (s_ok) tx_hist <= TX_OK;
         else if (s_fail && tx_hist != TX_NONE) tx_hist <= TX_FAILED;
      end
   end

   // power-connect sequence, started only when USB power appears
   wire usb_rise = s_usb && !usb_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         usb_q <= 1'b0;
         conn_act <= 1'b0;
         c_conn <= '0;
      end else begin
         usb_q <= s_usb;
         if (usb_rise && enable[lamp_pkg::EN_CONNECT]) begin
            conn_act <= 1'b1;
            c_conn <= '0;
         end else if (conn_act && tick) begin
            if (conn_end) begin
               conn_act <= 1'b0;
            end
            c_conn <= c_conn + 16'h0001;
         end
      end
   end

   wire sleep_on = c_sleep < T_ON;
   wire emg_on = c_emg < T_EMG;
   wire com_on = c_com < T_COM;
   wire [15:0] step = c_conn / T_STEP;
   wire [1:0] conn_idx = step[1:0];

   // asleep: normal pattern, or the emergency one when that is enabled and in tracking mode
   wire slp_allow = enable[lamp_pkg::EN_ASLEEP_NORM] || sleep_emerg;
   wire pw_asleep = slp_allow && sleep_on;
   wire pw_awake = enable[lamp_pkg::EN_AWAKE_NORM];
   wire pw_v = s_awake ? pw_awake : pw_asleep;
   wire lk_v = (s_bars >= B_SOLID) || (s_bars != 3'h0 && com_on);
   wire ps_v = (s_fix == lamp_pkg::FIX_VALID) ||
      (s_fix == lamp_pkg::FIX_PARTIAL && com_on);
   wire bt_full = !s_chg && (s_pct > P_HI || s_done);
   // charging only shows while switched on and awake
   wire bt_chg = s_pwr && s_awake && battery_charge_lamp_ph;
   wire bt_lvl = battery_charge_lamp_ph;
   wire bt_v = bt_full ? 1'b1 : (s_chg ? bt_chg : bt_lvl);
   wire st_v = (tx_hist == TX_OK) || (tx_hist == TX_FAILED && com_on);
   wire wl_v = (s_wl == lamp_pkg::WL_PAIRED) ||
      (s_wl == lamp_pkg::WL_PAIRING && com_on);

   wire emg_seq = s_emerg && s_awake && enable[lamp_pkg::EN_EMERG_SEQ];
   wire [lamp_pkg::LAMP_W-1:0] view_v = {wl_v, st_v, bt_v, ps_v, lk_v, pw_v};
   // power lamp is gated by its own pattern enables above
   wire [lamp_pkg::LAMP_W-1:0] lamp_en = {
      enable[lamp_pkg::EN_WIRELESS],
      enable[lamp_pkg::EN_STATUS],
      enable[lamp_pkg::EN_BATTERY_CHARGE_LAMP],
      enable[lamp_pkg::EN_POS],
      enable[lamp_pkg::EN_LINK],
      1'b1};
   logic [lamp_pkg::LAMP_W-1:0] normal;
   for (genvar i = 0; i < lamp_pkg::LAMP_W; i++) begin : g_gate
      assign normal[i] = view_v[i] && lamp_en[i];
   end
   wire [lamp_pkg::LAMP_W-1:0] rot = {1'b0,
      conn_idx == 2'h3, conn_idx == 2'h0, conn_idx == 2'h1,
      conn_idx == 2'h2, 1'b0};
   wire [lamp_pkg::LAMP_W-1:0] next_lamps = emg_seq ? {6{emg_on}}
      : (conn_act ? rot : normal);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lamps <= '0;
      end else begin
         lamps <= next_lamps;
      end
   end

   assign power_lamp_o = lamps[lamp_pkg::L_POWER];
   assign satellite_link_lamp_o = lamps[lamp_pkg::L_LINK];
   assign position_lamp_o = lamps[lamp_pkg::L_POS];
   assign battery_charge_lamp_o = lamps[lamp_pkg::L_BATTERY_CHARGE_LAMP];
   assign status_lamp_o = lamps[lamp_pkg::L_STATUS];
   assign wireless_pairing_lamp_o = lamps[lamp_pkg::L_WIRELESS];
endmodule
